// ==== rtl/sfp_defines.vh ====
`ifndef SFP_DEFINES_VH
`define SFP_DEFINES_VH

// ==========================================================================
// Register byte offsets
`define SFP_ADDR_CTRL    8'h00
`define SFP_ADDR_ZPTR    8'h04
`define SFP_ADDR_STORE   8'h08
`define SFP_ADDR_LOAD    8'h0C
`define SFP_ADDR_STATUS  8'h10

// ==========================================================================
// Control register fields and command patterns
`define SFP_CTRL_RST     5'h00
`define SFP_BIT_EN       0
`define SFP_BIT_BUSY     6
`define SFP_CMD_FILL     5'h01
`define SFP_CMD_ERASE    5'h03
`define SFP_CMD_WRITE    5'h05
`define SFP_CMD_LOCK     5'h09
`define SFP_CMD_REEN     5'h11
`define SFP_STORE_WINDOW 3'h4

// ==========================================================================
// Section limits, word addresses
`define SFP_BOOT_8K_11   13'h0F80
`define SFP_BOOT_8K_10   13'h0F00
`define SFP_BOOT_8K_01   13'h0E00
`define SFP_BOOT_8K_00   13'h0C00
`define SFP_BOOT_16K_11  13'h1F80
`define SFP_BOOT_16K_10  13'h1F00
`define SFP_BOOT_16K_01  13'h1E00
`define SFP_BOOT_16K_00  13'h1C00
`define SFP_BLOCKED_DURING_WRITE_SECTION_8K      13'h0C00
`define SFP_BLOCKED_DURING_WRITE_SECTION_16K     13'h1C00

// ==========================================================================
// Programming time, timed from the RC oscillator enable
`define SFP_CLK_PERIOD_NS 5
`define SFP_RC_DIV        25
`define SFP_PROG_MIN_NS   3700000
`define SFP_PROG_MAX_NS   4500000
`define SFP_RC_PERIOD_NS  (`SFP_CLK_PERIOD_NS * `SFP_RC_DIV)
`define SFP_PROG_TICKS    ((`SFP_PROG_MIN_NS + `SFP_RC_PERIOD_NS - 1) / `SFP_RC_PERIOD_NS)

// ==========================================================================
// Bus responses
`define SFP_RESP_OKAY    2'h0
`define SFP_RESP_SLVERR  2'h2

`endif

// ==== rtl/sfp_page_buf.v ====
`timescale 1ns/1ps

// Temporary page buffer; read data always come out of a register.
module sfp_page_buf #(
  parameter DW = 16,
  parameter AW = 6
) (
  // Clock
  input  wire          clk_i,
  // Write port
  input  wire          we_i,
  input  wire [AW-1:0] waddr_i,
  input  wire [DW-1:0] wdata_i,
  // Read port
  input  wire [AW-1:0] raddr_i,
  output reg  [DW-1:0] rdata_o
);

  reg [DW-1:0] mem_r [0:(1<<AW)-1];

  always @(posedge clk_i) begin
    if (we_i) begin
      mem_r[waddr_i] <= wdata_i;
    end
    rdata_o <= mem_r[raddr_i];
  end

endmodule // sfp_page_buf

// ==== rtl/sfp_prog_timer.v ====
`timescale 1ns/1ps

// Programming timer: a divider gives the RC-rate enable, a down counter
// counts those ticks. A restart while running is ignored.
module sfp_prog_timer #(
  parameter TICKS = 29600,
  parameter DIV   = 25
) (
  // Clock and reset
  input  wire clk_i,
  input  wire srst_i,
  // Control
  input  wire start_i,
  output reg  done_o
);

  reg [7:0]  div_r;
  reg [19:0] cnt_r;
  reg        run_r;
  wire       tick = (div_r == DIV[7:0] - 8'h01);

  always @(posedge clk_i) begin
    if (srst_i) begin
      div_r  <= 8'h00;
      cnt_r  <= 20'h00000;
      run_r  <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (!run_r) begin
        div_r <= 8'h00;
        if (start_i) begin
          run_r <= 1'b1;
          cnt_r <= TICKS[19:0];
        end
      end else begin
        div_r <= tick ? 8'h00 : div_r + 8'h01;
        if (tick) begin
          if (cnt_r == 20'h00001) begin
            run_r  <= 1'b0;
            done_o <= 1'b1;
          end
          cnt_r <= cnt_r - 20'h00001;
        end
      end
    end
  end

endmodule // sfp_prog_timer

// ==== rtl/sfp_flash_seq.v ====
`timescale 1ns/1ps
`include "sfp_defines.vh"

module sfp_flash_seq #(
  parameter BIG_VARIANT = 1,
  parameter PROG_TICKS  = `SFP_PROG_TICKS,
  parameter RC_DIV      = `SFP_RC_DIV
) (
  // Clock and reset
  input  wire        clk_i,
  input  wire        srst_i,
  // AXI4-Lite write address and data
  input  wire [7:0]  s_axi_awaddr_i,
  input  wire        s_axi_awvalid_i,
  output reg         s_axi_awready_o,
  input  wire [31:0] s_axi_wdata_i,
  input  wire [3:0]  s_axi_wstrb_i,
  input  wire        s_axi_wvalid_i,
  output reg         s_axi_wready_o,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp_o,
  output reg         s_axi_bvalid_o,
  input  wire        s_axi_bready_i,
  // AXI4-Lite read
  input  wire [7:0]  s_axi_araddr_i,
  input  wire        s_axi_arvalid_i,
  output reg         s_axi_arready_o,
  output reg  [31:0] s_axi_rdata_o,
  output reg  [1:0]  s_axi_rresp_o,
  output reg         s_axi_rvalid_o,
  input  wire        s_axi_rready_i,
  // Configuration and system status
  input  wire        boot_size_sel_hi_i,
  input  wire        boot_size_sel_lo_i,
  input  wire        eeprom_write_pending_i,
  // Instruction fetch gate
  input  wire [12:0] fetch_addr_i,
  output reg         fetch_allow_o,
  // Section map
  output reg  [12:0] boot_start_o,
  output reg  [12:0] app_end_o,
  // Flash array port
  output reg         flash_erase_o,
  output reg         flash_wen_o,
  output reg  [6:0]  flash_page_o,
  output reg  [5:0]  flash_word_o,
  output reg  [15:0] flash_wdata_o
);

  // ==========================================================================
  // Geometry
  localparam [5:0]  LAST_IDX = BIG_VARIANT ? 6'h3F : 6'h1F;
  localparam [12:0] BLOCKED_DURING_WRITE_SECTION     = BIG_VARIANT ? `SFP_BLOCKED_DURING_WRITE_SECTION_16K : `SFP_BLOCKED_DURING_WRITE_SECTION_8K;

  localparam [2:0] S_IDLE   = 3'b001;
  localparam [2:0] S_STREAM = 3'b010;
  localparam [2:0] S_WAIT   = 3'b100;

  // Page select out of the pointer; the top pointer bits never take part.
  function [6:0] page_of;
    input [15:0] z;
    begin
      page_of = BIG_VARIANT ? z[13:7] : z[12:6];
    end
  endfunction

  // Word index out of the pointer; bit 0 never addresses a word.
  function [5:0] word_of;
    input [15:0] z;
    begin
      word_of = BIG_VARIANT ? z[6:1] : {1'b0, z[5:1]};
    end
  endfunction

  function [12:0] page_base;
    input [6:0] pg;
    begin
      page_base = BIG_VARIANT ? {pg, 6'h00} : {1'b0, pg, 5'h00};
    end
  endfunction

  function [12:0] boot_start;
    input [1:0] sel;
    begin
      case (sel)
        2'b11:   boot_start = BIG_VARIANT ? `SFP_BOOT_16K_11 : `SFP_BOOT_8K_11;
        2'b10:   boot_start = BIG_VARIANT ? `SFP_BOOT_16K_10 : `SFP_BOOT_8K_10;
        2'b01:   boot_start = BIG_VARIANT ? `SFP_BOOT_16K_01 : `SFP_BOOT_8K_01;
        default: boot_start = BIG_VARIANT ? `SFP_BOOT_16K_00 : `SFP_BOOT_8K_00;
      endcase
    end
  endfunction

  // ==========================================================================
  // State
  reg [7:0]  awaddr_r;
  reg        aw_got_r;
  reg [15:0] wdata_r;
  reg [1:0]  wstrb_r;
  reg        w_got_r;
  reg [7:0]  araddr_r;
  reg        rd_pend_r;
  reg [4:0]  ctrl_r;
  reg [2:0]  window_r;
  reg        busy_r;
  reg [15:0] zptr_r;
  reg [2:0]  state_r;
  reg [5:0]  idx_r;
  reg        pipe_v_r;
  reg [5:0]  pipe_idx_r;
  reg        tstart_r;
  reg [1:0]  boot_sz_r;
  wire       t_done;
  wire [15:0] buf_rdata;

  wire wr_fire  = aw_got_r && w_got_r && !s_axi_bvalid_o;
  wire wr_ctrl  = wr_fire && (awaddr_r == `SFP_ADDR_CTRL);
  wire wr_zptr  = wr_fire && (awaddr_r == `SFP_ADDR_ZPTR);
  wire wr_store = wr_fire && (awaddr_r == `SFP_ADDR_STORE);
  wire wr_known = wr_ctrl || wr_zptr || wr_store;
  // A store outside the window, with bit 0 set, or while a command runs (state not S_IDLE) does nothing.
  wire store_go = wr_store && wstrb_r[0] && ctrl_r[`SFP_BIT_EN] && (window_r != 3'h0)
                  && !zptr_r[0] && (state_r == S_IDLE);
  wire buf_we   = store_go && (ctrl_r == `SFP_CMD_FILL);
  wire [5:0] buf_raddr = (state_r == S_STREAM) ? idx_r : word_of(zptr_r);

  // ==========================================================================
  // Submodules
  sfp_page_buf #(
    .DW (16),
    .AW (6)
  ) u_buf (
    .clk_i   (clk_i),
    .we_i    (buf_we),
    .waddr_i (word_of(zptr_r)),
    .wdata_i (wdata_r),
    .raddr_i (buf_raddr),
    .rdata_o (buf_rdata)
  );

  sfp_prog_timer #(
    .TICKS (PROG_TICKS),
    .DIV   (RC_DIV)
  ) u_timer (
    .clk_i   (clk_i),
    .srst_i  (srst_i),
    .start_i (tstart_r),
    .done_o  (t_done)
  );

  // ==========================================================================
  // AXI4-Lite slave
  always @(posedge clk_i) begin
    if (srst_i) begin
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o  <= 1'b1;
      s_axi_bvalid_o  <= 1'b0;
      s_axi_bresp_o   <= `SFP_RESP_OKAY;
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rresp_o   <= `SFP_RESP_OKAY;
      s_axi_rdata_o   <= 32'h00000000;
      aw_got_r        <= 1'b0;
      w_got_r         <= 1'b0;
      awaddr_r        <= 8'h00;
      wdata_r         <= 16'h0000;
      wstrb_r         <= 2'h0;
      araddr_r        <= 8'h00;
      rd_pend_r       <= 1'b0;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_got_r        <= 1'b1;
        awaddr_r        <= s_axi_awaddr_i;
        s_axi_awready_o <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_got_r        <= 1'b1;
        wdata_r        <= s_axi_wdata_i[15:0];
        wstrb_r        <= s_axi_wstrb_i[1:0];
        s_axi_wready_o <= 1'b0;
      end
      if (wr_fire) begin
        aw_got_r       <= 1'b0;
        w_got_r        <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o  <= wr_known ? `SFP_RESP_OKAY : `SFP_RESP_SLVERR;
      end
      if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o  <= 1'b0;
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o  <= 1'b1;
      end
      if (s_axi_arvalid_i && s_axi_arready_o) begin
        araddr_r        <= s_axi_araddr_i;
        rd_pend_r       <= 1'b1;
        s_axi_arready_o <= 1'b0;
      end
      // One cycle of wait lets the buffer's registered read settle.
      if (rd_pend_r) begin
        rd_pend_r      <= 1'b0;
        s_axi_rvalid_o <= 1'b1;
        s_axi_rresp_o  <= `SFP_RESP_OKAY;
        case (araddr_r)
          `SFP_ADDR_CTRL:   s_axi_rdata_o <= {25'h0, busy_r, 1'b0, ctrl_r};
          `SFP_ADDR_ZPTR:   s_axi_rdata_o <= {16'h0, zptr_r};
          `SFP_ADDR_STORE:  s_axi_rdata_o <= 32'h00000000;
          `SFP_ADDR_LOAD:   s_axi_rdata_o <= {24'h0, zptr_r[0] ? buf_rdata[15:8] : buf_rdata[7:0]};
          `SFP_ADDR_STATUS: s_axi_rdata_o <= {28'h0, boot_sz_r, state_r == S_IDLE, busy_r};
          default: begin
            s_axi_rdata_o <= 32'h00000000;
            s_axi_rresp_o <= `SFP_RESP_SLVERR;
          end
        endcase
      end
      if (s_axi_rvalid_o && s_axi_rready_i) begin
        s_axi_rvalid_o  <= 1'b0;
        s_axi_arready_o <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Command sequencer
  always @(posedge clk_i) begin
    if (srst_i) begin
      ctrl_r        <= `SFP_CTRL_RST;
      window_r      <= 3'h0;
      busy_r        <= 1'b0;
      zptr_r        <= 16'h0000;
      state_r       <= S_IDLE;
      idx_r         <= 6'h00;
      tstart_r      <= 1'b0;
      flash_erase_o <= 1'b0;
      flash_page_o  <= 7'h00;
      // Strap caught in the reset cycle and frozen afterwards.
      boot_sz_r     <= {boot_size_sel_hi_i, boot_size_sel_lo_i};
    end else begin
      tstart_r      <= 1'b0;
      flash_erase_o <= 1'b0;
      if (window_r != 3'h0) begin
        window_r <= window_r - 3'h1;
      end
      // The enable bit clears by itself when the window lapses unused.
      if (window_r == 3'h1 && !store_go && state_r == S_IDLE) begin
        ctrl_r <= `SFP_CTRL_RST;
      end
      if (wr_zptr && wstrb_r == 2'h3) begin
        zptr_r <= wdata_r;
      end
      // A pending EEPROM write or a running command locks the control register.
      if (wr_ctrl && wstrb_r[0] && !eeprom_write_pending_i && !ctrl_r[`SFP_BIT_EN]) begin
        ctrl_r   <= wdata_r[4:0];
        window_r <= `SFP_STORE_WINDOW;
      end
      case (state_r)
        S_IDLE: begin
          if (store_go) begin
            window_r <= 3'h0;
            case (ctrl_r)
              `SFP_CMD_ERASE: begin
                flash_erase_o <= 1'b1;
                flash_page_o  <= page_of(zptr_r);
                tstart_r      <= 1'b1;
                state_r       <= S_WAIT;
                busy_r        <= busy_r || (page_base(page_of(zptr_r)) < BLOCKED_DURING_WRITE_SECTION);
              end
              `SFP_CMD_WRITE: begin
                flash_page_o <= page_of(zptr_r);
                idx_r        <= 6'h00;
                state_r      <= S_STREAM;
                busy_r       <= busy_r || (page_base(page_of(zptr_r)) < BLOCKED_DURING_WRITE_SECTION);
              end
              `SFP_CMD_LOCK: begin
                tstart_r <= 1'b1;
                state_r  <= S_WAIT;
              end
              `SFP_CMD_REEN: begin
                busy_r <= 1'b0;
                ctrl_r <= `SFP_CTRL_RST;
              end
              default: ctrl_r <= `SFP_CTRL_RST;
            endcase
          end
        end
        S_STREAM: begin
          idx_r <= idx_r + 6'h01;
          if (idx_r == LAST_IDX) begin
            tstart_r <= 1'b1;
            state_r  <= S_WAIT;
          end
        end
        S_WAIT: begin
          if (t_done) begin
            ctrl_r  <= `SFP_CTRL_RST;
            state_r <= S_IDLE;
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Page write stream, fetch gate and section map
  always @(posedge clk_i) begin
    if (srst_i) begin
      pipe_v_r      <= 1'b0;
      pipe_idx_r    <= 6'h00;
      flash_wen_o   <= 1'b0;
      flash_word_o  <= 6'h00;
      flash_wdata_o <= 16'h0000;
      fetch_allow_o <= 1'b1;
      boot_start_o  <= 13'h0000;
      app_end_o     <= 13'h0000;
    end else begin
      // Buffer data lag their address by one cycle, so the index is piped.
      pipe_v_r      <= (state_r == S_STREAM);
      pipe_idx_r    <= idx_r;
      flash_wen_o   <= pipe_v_r;
      flash_word_o  <= pipe_idx_r;
      flash_wdata_o <= buf_rdata;
      fetch_allow_o <= !busy_r || (fetch_addr_i >= BLOCKED_DURING_WRITE_SECTION);
      boot_start_o  <= boot_start(boot_sz_r);
      app_end_o     <= boot_start(boot_sz_r) - 13'h0001;
    end
  end

endmodule // sfp_flash_seq

// ==== tb/sfp_flash_seq_chk.sv ====
`timescale 1ns/1ps
// ==========================================================================
// Port checks for the flash sequencer.
module sfp_flash_seq_chk #(
  parameter PROG_TICKS  = 4,
  parameter RC_DIV      = 2,
  parameter BIG_VARIANT = 1
) (
  // Clock and reset
  input wire        clk_i,
  input wire        srst_i,
  // Bus handshakes
  input wire        s_axi_awready_o,
  input wire        s_axi_bvalid_o,
  input wire        s_axi_arvalid_i,
  input wire        s_axi_arready_o,
  input wire        s_axi_rvalid_o,
  // Map and flash port
  input wire [12:0] fetch_addr_i,
  input wire        fetch_allow_o,
  input wire [12:0] boot_start_o,
  input wire [12:0] app_end_o,
  input wire        flash_erase_o,
  input wire        flash_wen_o,
  input wire [5:0]  flash_word_o
);
  localparam int GAP = PROG_TICKS * RC_DIV;
  localparam [5:0]  LAST = BIG_VARIANT ? 6'h3F : 6'h1F;
  localparam [12:0] BLOCKED_DURING_WRITE_SECTION = BIG_VARIANT ? 13'h1C00 : 13'h0C00;
  reg [15:0] gap_r;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // Cycles since the last flash action; it saturates so a long idle never wraps.
  always @(posedge clk_i) begin
    if (srst_i) gap_r <= 16'hFFFF;
    else if (flash_erase_o || flash_wen_o) gap_r <= 16'h0000;
    else if (gap_r != 16'hFFFF) gap_r <= gap_r + 16'h0001;
  end
  sequence word_step_s;
    flash_wen_o && flash_word_o == $past(flash_word_o) + 6'h01;
  endsequence
  sequence stream_tail_s;
    !flash_wen_o && $past(flash_word_o) == LAST;
  endsequence
  stream_start_a: assert property ($rose(flash_wen_o) |-> flash_word_o == 6'h00)
    else $error("write stream does not start at word zero");
  stream_step_a: assert property (flash_wen_o && flash_word_o != LAST |=> word_step_s)
    else $error("write stream skipped a word");
  stream_end_a: assert property (flash_wen_o && flash_word_o == LAST |=> stream_tail_s)
    else $error("write stream did not stop after the last word");
  erase_pulse_a: assert property (flash_erase_o |=> !flash_erase_o && !flash_wen_o)
    else $error("erase pulse too long");
  prog_gap_a: assert property ((flash_erase_o || $rose(flash_wen_o)) |-> gap_r >= GAP)
    else $error("flash action before programming time ran out");
  app_end_a: assert property (!$past(srst_i) |-> app_end_o == boot_start_o - 13'h0001)
    else $error("application end not one below boot start");
  boot_hold_a: assert property (!$past(srst_i) && !$past(srst_i, 2) |-> $stable(boot_start_o))
    else $error("boot start changed while running");
  fetch_gate_a: assert property (!$past(srst_i) && $past(fetch_addr_i) >= BLOCKED_DURING_WRITE_SECTION |-> fetch_allow_o)
    else $error("fetch from blocked-during-write section refused");
  bus_busy_a: assert property (s_axi_bvalid_o |-> !s_axi_awready_o)
    else $error("write address taken during response");
  read_lat_a: assert property (s_axi_arvalid_i && s_axi_arready_o |-> ##[1:2] s_axi_rvalid_o)
    else $error("read answer late");
endmodule // sfp_flash_seq_chk

bind sfp_flash_seq sfp_flash_seq_chk #(.PROG_TICKS(PROG_TICKS), .RC_DIV(RC_DIV), .BIG_VARIANT(BIG_VARIANT)) chk_u (
  .clk_i(clk_i), .srst_i(srst_i), .s_axi_awready_o(s_axi_awready_o), .s_axi_bvalid_o(s_axi_bvalid_o),
  .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o), .s_axi_rvalid_o(s_axi_rvalid_o),
  .fetch_addr_i(fetch_addr_i), .fetch_allow_o(fetch_allow_o), .boot_start_o(boot_start_o),
  .app_end_o(app_end_o), .flash_erase_o(flash_erase_o), .flash_wen_o(flash_wen_o),
  .flash_word_o(flash_word_o));

// ==== tb/sfp_flash_model.sv ====
`timescale 1ns/1ps
// ==========================================================================
// Flash array stand-in: it records what the sequencer does to the cells.
module sfp_flash_model (
  // Clock and reset
  input  wire        clk_i,
  input  wire        srst_i,
  // Array port
  input  wire        erase_i,
  input  wire        wen_i,
  input  wire [6:0]  page_i,
  input  wire [5:0]  word_i,
  input  wire [15:0] wdata_i,
  // Observation
  output reg  [7:0]  n_erase_o,
  output reg  [7:0]  n_word_o,
  output reg  [6:0]  page_o,
  output reg  [15:0] last_o
);
  always @(posedge clk_i) begin
    if (srst_i) begin
      n_erase_o <= 8'h00;
      n_word_o <= 8'h00;
      page_o <= 7'h00;
      last_o <= 16'h0000;
    end else begin
      if (erase_i) n_erase_o <= n_erase_o + 8'h01;
      if (erase_i || wen_i) page_o <= page_i;
      if (wen_i) n_word_o <= n_word_o + 8'h01;
      if (wen_i && word_i == 6'h3F) last_o <= wdata_i;
    end
  end
endmodule // sfp_flash_model

// ==== tb/sfp_flash_seq_bench.sv ====
`timescale 1ns/1ps
`include "sfp_defines.vh"
// ==========================================================================
// Bench: register traffic through the bus, checked against the flash map.
module sfp_flash_seq_bench;
  reg        clk_r = 1'h0;
  reg        srst_r = 1'h1;
  reg [7:0]  awa_r = 8'h00;
  reg        awv_r = 1'h0;
  reg [31:0] wd_r = 32'h0;
  reg        wv_r = 1'h0;
  reg [7:0]  ara_r = 8'h00;
  reg        arv_r = 1'h0;
  reg [1:0]  sel_r = 2'h3;
  reg        eep_r = 1'h0;
  reg [12:0] fa_r = 13'h1C00;
  reg [3:0]  ws_r = 4'hF;
  reg        br_r = 1'h1;
  reg        rr_r = 1'h1;
  reg [31:0] rd;
  reg [13:0] be;
  integer    n_mismatch = 0;
  integer    n_checks = 0;
  integer    cyc = 0;
  integer    i;
  wire       awready, wready, bvalid, arready, rvalid, fallow, ers, wen;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [12:0] bstart, aend;
  wire [6:0] fpage, mpage;
  wire [5:0] fword;
  wire [15:0] fdata, mlast;
  wire [7:0] n_ers, n_wrd;
  wire       fallow8;
  wire [12:0] bstart8, aend8;
  wire [6:0] fpage8;

  always #2.5 clk_r = ~clk_r;

  sfp_flash_seq #(.BIG_VARIANT(1), .PROG_TICKS(4), .RC_DIV(2)) dut_u (
    .clk_i(clk_r), .srst_i(srst_r), .s_axi_awaddr_i(awa_r), .s_axi_awvalid_i(awv_r),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wd_r), .s_axi_wstrb_i(ws_r), .s_axi_wvalid_i(wv_r),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(br_r),
    .s_axi_araddr_i(ara_r), .s_axi_arvalid_i(arv_r), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rr_r), .boot_size_sel_hi_i(sel_r[1]),
    .boot_size_sel_lo_i(sel_r[0]), .eeprom_write_pending_i(eep_r), .fetch_addr_i(fa_r),
    .fetch_allow_o(fallow), .boot_start_o(bstart), .app_end_o(aend), .flash_erase_o(ers),
    .flash_wen_o(wen), .flash_page_o(fpage), .flash_word_o(fword), .flash_wdata_o(fdata));

  // Small variant on the same bus; its handshakes match the large one cycle for cycle.
  sfp_flash_seq #(.BIG_VARIANT(0), .PROG_TICKS(4), .RC_DIV(2)) dut8_u (
    .clk_i(clk_r), .srst_i(srst_r), .s_axi_awaddr_i(awa_r), .s_axi_awvalid_i(awv_r),
    .s_axi_awready_o(), .s_axi_wdata_i(wd_r), .s_axi_wstrb_i(ws_r), .s_axi_wvalid_i(wv_r),
    .s_axi_wready_o(), .s_axi_bresp_o(), .s_axi_bvalid_o(), .s_axi_bready_i(br_r),
    .s_axi_araddr_i(ara_r), .s_axi_arvalid_i(arv_r), .s_axi_arready_o(), .s_axi_rdata_o(),
    .s_axi_rresp_o(), .s_axi_rvalid_o(), .s_axi_rready_i(rr_r), .boot_size_sel_hi_i(sel_r[1]),
    .boot_size_sel_lo_i(sel_r[0]), .eeprom_write_pending_i(eep_r), .fetch_addr_i(fa_r),
    .fetch_allow_o(fallow8), .boot_start_o(bstart8), .app_end_o(aend8), .flash_erase_o(),
    .flash_wen_o(), .flash_page_o(fpage8), .flash_word_o(), .flash_wdata_o());

  sfp_flash_model model_u (
    .clk_i(clk_r), .srst_i(srst_r), .erase_i(ers), .wen_i(wen), .page_i(fpage), .word_i(fword),
    .wdata_i(fdata), .n_erase_o(n_ers), .n_word_o(n_wrd), .page_o(mpage), .last_o(mlast));

  task chk(input string nm, input [31:0] exp, input [31:0] got);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask

  task axw(input [7:0] a, input [31:0] d, input [1:0] er);
    begin
      awa_r <= a;
      wd_r <= d;
      awv_r <= 1'h1;
      wv_r <= 1'h1;
      forever begin
        @(posedge clk_r);
        if (awv_r && awready) awv_r <= 1'h0;
        if (wv_r && wready) wv_r <= 1'h0;
        if (bvalid) break;
      end
      chk("bresp", {30'h0, er}, {30'h0, bresp});
    end
  endtask

  task axr(input [7:0] a, input [1:0] er);
    begin
      ara_r <= a;
      arv_r <= 1'h1;
      forever begin
        @(posedge clk_r);
        if (arv_r && arready) arv_r <= 1'h0;
        if (rvalid) break;
      end
      rd = rdata;
      chk("rresp", {30'h0, er}, {30'h0, rresp});
    end
  endtask

  task rst(input [1:0] s);
    begin
      sel_r <= s;
      srst_r <= 1'h1;
      repeat (20) @(posedge clk_r);
      srst_r <= 1'h0;
      repeat (2) @(posedge clk_r);
    end
  endtask

  task idle_wait;
    begin
      rd = 32'h1;
      while (rd[0] === 1'h1) axr(`SFP_ADDR_CTRL, `SFP_RESP_OKAY);
    end
  endtask

  // The enable bit is polled first, so a command never overlaps the last one.
  task cmd(input [4:0] c, input [15:0] z, input [15:0] d);
    begin
      idle_wait;
      axw(`SFP_ADDR_ZPTR, {16'h0, z}, `SFP_RESP_OKAY);
      axw(`SFP_ADDR_CTRL, {27'h0, c}, `SFP_RESP_OKAY);
      axw(`SFP_ADDR_STORE, {16'h0, d}, `SFP_RESP_OKAY);
    end
  endtask

  task ld(input [15:0] z, input [31:0] e);
    begin
      axw(`SFP_ADDR_ZPTR, {16'h0, z}, `SFP_RESP_OKAY);
      axr(`SFP_ADDR_LOAD, `SFP_RESP_OKAY);
      chk("load", e, rd);
    end
  endtask

  task fet(input [12:0] a, input e, input e8);
    begin
      fa_r <= a;
      repeat (3) @(posedge clk_r);
      chk("fetch", {31'h0, e}, {31'h0, fallow});
      chk("fetch8", {31'h0, e8}, {31'h0, fallow8});
    end
  endtask

  task wrap_up;
    begin
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
        $display("verification passed");
      end else begin
        $display("verification failed");
      end
      $finish;
    end
  endtask

  // A hang anywhere ends the run as a failure.
  always @(posedge clk_r) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch = n_mismatch + 1;
      wrap_up;
    end
  end

  initial begin
    for (i = 0; i < 4; i = i + 1) begin
      rst(i[1:0]);
      be = 14'h2000 - (14'h0080 << (2'h3 - i[1:0]));
      chk("boot_start", {19'h0, be[12:0]}, {19'h0, bstart});
      chk("app_end", {19'h0, be[12:0] - 13'h0001}, {19'h0, aend});
      chk("boot_start8", {19'h0, be[12:0] - 13'h1000}, {19'h0, bstart8});
      chk("app_end8", {19'h0, be[12:0] - 13'h1001}, {19'h0, aend8});
      sel_r <= ~i[1:0];
      repeat (3) @(posedge clk_r);
      chk("boot_held", {19'h0, be[12:0]}, {19'h0, bstart});
    end
    axw(8'h20, 32'h0, `SFP_RESP_SLVERR);
    axr(8'h20, `SFP_RESP_SLVERR);
    chk("unmapped", 32'h0, rd);
    cmd(`SFP_CMD_ERASE, 16'h0280, 16'h0000);
    cmd(`SFP_CMD_FILL, 16'h0002, 16'h0000);
    chk("erase_page", 32'h5, {25'h0, mpage});
    chk("erase_page8", 32'hA, {25'h0, fpage8});
    chk("erases", 32'h1, {24'h0, n_ers});
    axr(`SFP_ADDR_STATUS, `SFP_RESP_OKAY);
    chk("status", 32'hF, rd);
    fet(13'h1BFF, 1'h0, 1'h1);
    fet(13'h1C00, 1'h1, 1'h1);
    fet(13'h0BFF, 1'h0, 1'h0);
    fet(13'h0C00, 1'h0, 1'h1);
    cmd(`SFP_CMD_REEN, 16'h0000, 16'h0000);
    axr(`SFP_ADDR_STATUS, `SFP_RESP_OKAY);
    chk("status", 32'hE, rd);
    fet(13'h0BFF, 1'h1, 1'h1);
    cmd(`SFP_CMD_FILL, 16'h0002, 16'h1234);
    cmd(`SFP_CMD_FILL, 16'hC07E, 16'hA55A);
    cmd(`SFP_CMD_FILL, 16'h0003, 16'hBEEF);
    ld(16'h0002, 32'h34);
    ld(16'h0003, 32'h12);
    ld(16'hC07E, 32'h5A);
    ld(16'h007F, 32'hA5);
    // A pointer write needs both low byte strobes; one alone leaves it as it was.
    ws_r <= 4'h1;
    axw(`SFP_ADDR_ZPTR, 32'h0000FFFF, `SFP_RESP_OKAY);
    ws_r <= 4'hF;
    axr(`SFP_ADDR_ZPTR, `SFP_RESP_OKAY);
    chk("zptr_half", 32'h007F, rd);
    cmd(`SFP_CMD_WRITE, 16'h0280, 16'h0000);
    cmd(`SFP_CMD_REEN, 16'h0000, 16'h0000);
    chk("words", 32'h40, {24'h0, n_wrd});
    chk("write_page", 32'h5, {25'h0, mpage});
    chk("write_page8", 32'hA, {25'h0, fpage8});
    chk("last_word", 32'hA55A, {16'h0, mlast});
    cmd(`SFP_CMD_LOCK, 16'h0001, 16'h00FF);
    idle_wait;
    eep_r <= 1'h1;
    axw(`SFP_ADDR_CTRL, {27'h0, `SFP_CMD_ERASE}, `SFP_RESP_OKAY);
    axr(`SFP_ADDR_CTRL, `SFP_RESP_OKAY);
    chk("ctrl_blocked", 32'h0, rd);
    eep_r <= 1'h0;
    axw(`SFP_ADDR_ZPTR, 32'h0280, `SFP_RESP_OKAY);
    axw(`SFP_ADDR_CTRL, {27'h0, `SFP_CMD_ERASE}, `SFP_RESP_OKAY);
    repeat (5) @(posedge clk_r);
    axw(`SFP_ADDR_STORE, 32'h0, `SFP_RESP_OKAY);
    repeat (4) @(posedge clk_r);
    chk("late_store", 32'h1, {24'h0, n_ers});
    chk("lock_words", 32'h40, {24'h0, n_wrd});
    wrap_up;
  end
endmodule // sfp_flash_seq_bench
